//--- include/csss_pkg.sv
// Constants, source codes and shared types of the control signal source selector
//
// Overview of operation
// - Code 6 gives a constant high level, code 7 a constant low level.
// - Code 13 gives technology controller start, valid only in its configurations.
// - Code 70 is drive release: both torque-off enables high together.
// - Codes 71 to 75 follow terminal inputs 2 to 6, or remote values.
// - Code 76 follows multifunction input in digital mode 3 without remote enable, else remote value.
// - Code 157 is high when any mask-enabled warning is critical.
// - Codes 158 and 159 carry the first and second timer outputs.
// - Code 160 is high once the drive is initialized and ready.
// - Code 161 needs both enables, a start command and output frequency.
// - Code 162 is high whenever monitoring reports an operational fault.
// - Reference frequency reached is high when actual meets reference frequency.
// - Code 164 is high while stator frequency exceeds setting frequency.
// - Code 165 is high when monitoring reports current-time overload.
// - Heat sink warning when temperature reaches 80 degrees minus margin.
// - Code 167 when inside temperature reaches 65 degrees minus margin.
// - Code 168 per motor temperature mode when thermistor reports maximum.
// - Code 169 is high when the general warning status shows a critical warning.
// - Code 170 is the OR of heat sink and inside temperature warnings.
// - Codes 171 and 173 follow the first and second comparator outputs.
// - Codes 172 and 174 are the inverted comparator outputs.
// - Codes 175 to 177 reproduce the digital output one, three and multifunction signals.
// - Code 178 is high when actual percentage reaches reference percentage.
// - Codes 270 to 276 are inverted versions of codes 70 to 76.
package csss_pkg;

    // Function inputs served
    localparam int FUNC_COUNT   = 8;
    localparam int FUNC_INDEX_W = 3;

    // Source code field
    localparam int CODE_W = 9;
    localparam logic [CODE_W-1:0] CODE_ON             = 9'h006;
    localparam logic [CODE_W-1:0] CODE_OFF            = 9'h007;
    localparam logic [CODE_W-1:0] CODE_TECH_START     = 9'h00D;
    localparam logic [CODE_W-1:0] CODE_DRIVE_RELEASE  = 9'h046;
    localparam logic [CODE_W-1:0] CODE_MULTIFUNCTION  = 9'h04C;
    localparam logic [CODE_W-1:0] CODE_WARNING_MASK   = 9'h09D;
    localparam logic [CODE_W-1:0] CODE_TIMER_1        = 9'h09E;
    localparam logic [CODE_W-1:0] CODE_TIMER_2        = 9'h09F;
    localparam logic [CODE_W-1:0] CODE_READY          = 9'h0A0;
    localparam logic [CODE_W-1:0] CODE_RUN            = 9'h0A1;
    localparam logic [CODE_W-1:0] CODE_ERROR          = 9'h0A2;
    localparam logic [CODE_W-1:0] CODE_FREQ_REACHED   = 9'h0A3;
    localparam logic [CODE_W-1:0] CODE_SETTING_FREQ   = 9'h0A4;
    localparam logic [CODE_W-1:0] CODE_OVERLOAD       = 9'h0A5;
    localparam logic [CODE_W-1:0] CODE_HEAT_SINK      = 9'h0A6;
    localparam logic [CODE_W-1:0] CODE_INSIDE_TEMP    = 9'h0A7;
    localparam logic [CODE_W-1:0] CODE_MOTOR_TEMP     = 9'h0A8;
    localparam logic [CODE_W-1:0] CODE_GENERAL_WARN   = 9'h0A9;
    localparam logic [CODE_W-1:0] CODE_OVER_TEMP      = 9'h0AA;
    localparam logic [CODE_W-1:0] CODE_COMP_1         = 9'h0AB;
    localparam logic [CODE_W-1:0] CODE_COMP_1_N       = 9'h0AC;
    localparam logic [CODE_W-1:0] CODE_COMP_2         = 9'h0AD;
    localparam logic [CODE_W-1:0] CODE_COMP_2_N       = 9'h0AE;
    localparam logic [CODE_W-1:0] CODE_DIGITAL_1      = 9'h0AF;
    localparam logic [CODE_W-1:0] CODE_DIGITAL_2      = 9'h0B0;
    localparam logic [CODE_W-1:0] CODE_DIGITAL_3      = 9'h0B1;
    localparam logic [CODE_W-1:0] CODE_PERCENT_REACH  = 9'h0B2;
    localparam logic [CODE_W-1:0] CODE_INV_FIRST      = 9'h10E;
    localparam logic [CODE_W-1:0] CODE_INV_LAST       = 9'h114;
    localparam logic [CODE_W-1:0] CODE_RESET          = CODE_OFF;

    // Input group 70 to 76
    localparam int INPUT_GROUP_W = 7;
    localparam int INPUT_IDX_W   = 3;

    // Device configurations with a technology controller
    localparam int CONFIG_W = 9;
    localparam logic [CONFIG_W-1:0] CONFIG_TECH_A = 9'h06F;
    localparam logic [CONFIG_W-1:0] CONFIG_TECH_B = 9'h0D3;
    localparam logic [CONFIG_W-1:0] CONFIG_TECH_C = 9'h19B;

    // Multifunction input mode for digital operation
    localparam int MF_MODE_W = 4;
    localparam logic [MF_MODE_W-1:0] MF_MODE_DIGITAL = 4'h3;

    // Motor temperature mode that disables the warning
    localparam int MOTOR_MODE_W = 4;
    localparam logic [MOTOR_MODE_W-1:0] MOTOR_MODE_OFF = 4'h0;

    // Temperatures in whole degrees C
    localparam int TEMP_W = 8;
    localparam logic [TEMP_W-1:0] HEAT_SINK_MAX_C = 8'h50;
    localparam logic [TEMP_W-1:0] INSIDE_MAX_C    = 8'h41;

    // Measurement widths
    localparam int FREQ_W    = 16;
    localparam int PERCENT_W = 16;
    localparam int WARN_W    = 16;

    // Remote inputs: terminals 2 to 6 then multifunction
    localparam int TERMINAL_COUNT = 5;
    localparam int REMOTE_W       = 6;
    localparam int REMOTE_MF_BIT  = 5;

    // Pins passing the synchronizer
    localparam int PIN_W            = 8;
    localparam int PIN_ENABLE_A     = 0;
    localparam int PIN_ENABLE_B     = 1;
    localparam int PIN_TERMINAL_LSB = 2;
    localparam int PIN_MULTIFUNC    = 7;

    // Selectable internal sources
    typedef struct packed {
        logic                      tech_start;
        logic [INPUT_GROUP_W-1:0]  input_group;
        logic                      warning_mask;
        logic                      timer_1;
        logic                      timer_2;
        logic                      ready;
        logic                      run;
        logic                      error;
        logic                      freq_reached;
        logic                      setting_freq;
        logic                      overload;
        logic                      heat_sink;
        logic                      inside_temp;
        logic                      motor_temp;
        logic                      general_warn;
        logic                      over_temp;
        logic                      comp_1;
        logic                      comp_2;
        logic                      digital_1;
        logic                      digital_2;
        logic                      digital_3;
        logic                      percent_reach;
    } csss_sources_type;

endpackage

//--- include/csss_src_if.sv
// Source flag carrier between the top and the selectors
`timescale 1ns/1ns
interface csss_src_if;
    csss_pkg::csss_sources_type src;
    modport drive (output src);
    modport take  (input  src);
endinterface

//--- src/csss_selector.sv
// One function input: stored source code and registered level
`timescale 1ns/1ns
module csss_selector (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Code load
    input  wire logic                          load,
    input  wire logic [csss_pkg::CODE_W-1:0]   load_code,
    // Sources
    csss_src_if.take                           srcs,
    // Level
    output      logic                          level
);

    logic [csss_pkg::CODE_W-1:0] code;
    logic [csss_pkg::CODE_W-1:0] offs;
    logic                        next_level;

    // Stored code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            code <= csss_pkg::CODE_RESET;
        end else if (load) begin
            code <= load_code;
        end
    end

    // Source decode
    always_comb begin
        offs       = '0;
        next_level = 1'b0;
        if (code >= csss_pkg::CODE_DRIVE_RELEASE && code <= csss_pkg::CODE_MULTIFUNCTION) begin
            offs       = code - csss_pkg::CODE_DRIVE_RELEASE;
            next_level = srcs.src.input_group[offs[csss_pkg::INPUT_IDX_W-1:0]];
        end else if (code >= csss_pkg::CODE_INV_FIRST && code <= csss_pkg::CODE_INV_LAST) begin
            offs       = code - csss_pkg::CODE_INV_FIRST;
            next_level = ~srcs.src.input_group[offs[csss_pkg::INPUT_IDX_W-1:0]];
        end else begin
            case (code)
                csss_pkg::CODE_ON:            next_level = 1'b1;
                csss_pkg::CODE_OFF:           next_level = 1'b0;
                csss_pkg::CODE_TECH_START:    next_level = srcs.src.tech_start;
                csss_pkg::CODE_WARNING_MASK:  next_level = srcs.src.warning_mask;
                csss_pkg::CODE_TIMER_1:       next_level = srcs.src.timer_1;
                csss_pkg::CODE_TIMER_2:       next_level = srcs.src.timer_2;
                csss_pkg::CODE_READY:         next_level = srcs.src.ready;
                csss_pkg::CODE_RUN:           next_level = srcs.src.run;
                csss_pkg::CODE_ERROR:         next_level = srcs.src.error;
                csss_pkg::CODE_FREQ_REACHED:  next_level = srcs.src.freq_reached;
                csss_pkg::CODE_SETTING_FREQ:  next_level = srcs.src.setting_freq;
                csss_pkg::CODE_OVERLOAD:      next_level = srcs.src.overload;
                csss_pkg::CODE_HEAT_SINK:     next_level = srcs.src.heat_sink;
                csss_pkg::CODE_INSIDE_TEMP:   next_level = srcs.src.inside_temp;
                csss_pkg::CODE_MOTOR_TEMP:    next_level = srcs.src.motor_temp;
                csss_pkg::CODE_GENERAL_WARN:  next_level = srcs.src.general_warn;
                csss_pkg::CODE_OVER_TEMP:     next_level = srcs.src.over_temp;
                csss_pkg::CODE_COMP_1:        next_level = srcs.src.comp_1;
                csss_pkg::CODE_COMP_1_N:      next_level = ~srcs.src.comp_1;
                csss_pkg::CODE_COMP_2:        next_level = srcs.src.comp_2;
                csss_pkg::CODE_COMP_2_N:      next_level = ~srcs.src.comp_2;
                csss_pkg::CODE_DIGITAL_1:     next_level = srcs.src.digital_1;
                csss_pkg::CODE_DIGITAL_2:     next_level = srcs.src.digital_2;
                csss_pkg::CODE_DIGITAL_3:     next_level = srcs.src.digital_3;
                csss_pkg::CODE_PERCENT_REACH: next_level = srcs.src.percent_reach;
                default:                      next_level = 1'b0;
            endcase
        end
    end

    // Registered level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

endmodule

//--- src/csss_top.sv
// Control signal source selector top: pin sync, source flags, function inputs
`timescale 1ns/1ns
module csss_top (
    // Clock and reset
    input  wire logic                                  clk,
    input  wire logic                                  rst_n,

    // Function input code programming
    input  wire logic                                  cfg_write,
    input  wire logic [csss_pkg::FUNC_INDEX_W-1:0]     cfg_index,
    input  wire logic [csss_pkg::CODE_W-1:0]           cfg_code,

    // Terminal pins
    input  wire logic                                  torque_off_enable_a,
    input  wire logic                                  torque_off_enable_b,
    input  wire logic                                  terminal_input_2,
    input  wire logic                                  terminal_input_3,
    input  wire logic                                  terminal_input_4,
    input  wire logic                                  terminal_input_5,
    input  wire logic                                  terminal_input_6,
    input  wire logic                                  multifunction_input,

    // Remote operation over the communication interface
    input  wire logic [csss_pkg::REMOTE_W-1:0]         remote_enable,
    input  wire logic [csss_pkg::REMOTE_W-1:0]         remote_value,
    input  wire logic [csss_pkg::MF_MODE_W-1:0]        multifunction_mode,

    // Configuration
    input  wire logic [csss_pkg::CONFIG_W-1:0]         device_config,
    input  wire logic [csss_pkg::MOTOR_MODE_W-1:0]     motor_temp_mode,
    input  wire logic [csss_pkg::WARN_W-1:0]           warning_mask,
    input  wire logic [csss_pkg::TEMP_W-1:0]           heat_sink_margin,
    input  wire logic [csss_pkg::TEMP_W-1:0]           inside_margin,
    input  wire logic [csss_pkg::FREQ_W-1:0]           setting_freq,

    // Drive status
    input  wire logic                                  tech_start_cmd,
    input  wire logic                                  timer_1_out,
    input  wire logic                                  timer_2_out,
    input  wire logic                                  init_done,
    input  wire logic                                  start_cmd,
    input  wire logic                                  freq_output_active,
    input  wire logic                                  fault_reported,
    input  wire logic                                  overload_reported,
    input  wire logic                                  thermistor_max,
    input  wire logic                                  comp_1_out,
    input  wire logic                                  comp_2_out,
    input  wire logic                                  digital_signal_1,
    input  wire logic                                  digital_signal_2,
    input  wire logic                                  digital_signal_3,

    // Warnings
    input  wire logic [csss_pkg::WARN_W-1:0]           warning_active,
    input  wire logic [csss_pkg::WARN_W-1:0]           warning_critical,

    // Measurements
    input  wire logic [csss_pkg::FREQ_W-1:0]           actual_freq,
    input  wire logic [csss_pkg::FREQ_W-1:0]           reference_freq,
    input  wire logic [csss_pkg::FREQ_W-1:0]           stator_freq,
    input  wire logic [csss_pkg::PERCENT_W-1:0]        actual_percent,
    input  wire logic [csss_pkg::PERCENT_W-1:0]        reference_percent,
    input  wire logic [csss_pkg::TEMP_W-1:0]           heat_sink_temp,
    input  wire logic [csss_pkg::TEMP_W-1:0]           inside_temp,

    // Function input levels
    output      logic [csss_pkg::FUNC_COUNT-1:0]       func_level,

    // Synchronized pin levels
    output      logic [csss_pkg::PIN_W-1:0]            pin_level
);

    // Reset release chain
    logic                              rst_meta_n;
    logic                              sys_rst_n;

    // Pin synchronizer
    logic [csss_pkg::PIN_W-1:0]        pin_raw;
    logic [csss_pkg::PIN_W-1:0]        pin_meta;
    logic [csss_pkg::PIN_W-1:0]        pin_sync;

    // Derived terms
    logic [csss_pkg::TERMINAL_COUNT-1:0] terminal_sync;
    logic [csss_pkg::TERMINAL_COUNT-1:0] terminal_src;
    logic                              multifunction_src;
    logic                              both_enables;
    logic                              tech_config;
    logic [csss_pkg::TEMP_W:0]         heat_sink_sum;
    logic [csss_pkg::TEMP_W:0]         inside_sum;
    logic                              heat_sink_hit;
    logic                              inside_hit;
    logic [csss_pkg::FUNC_COUNT-1:0]   level;

    // Source carrier
    csss_src_if srcs ();

    // Reset release
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            sys_rst_n  <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            sys_rst_n  <= rst_meta_n;
        end
    end

    // Pin gathering
    assign pin_raw[csss_pkg::PIN_ENABLE_A]  = torque_off_enable_a;
    assign pin_raw[csss_pkg::PIN_ENABLE_B]  = torque_off_enable_b;
    assign pin_raw[csss_pkg::PIN_TERMINAL_LSB +: csss_pkg::TERMINAL_COUNT] = {
        terminal_input_6,
        terminal_input_5,
        terminal_input_4,
        terminal_input_3,
        terminal_input_2
    };
    assign pin_raw[csss_pkg::PIN_MULTIFUNC] = multifunction_input;

    // Two-stage pin synchronizer
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_raw;
            pin_sync <= pin_meta;
        end
    end

    // Synchronized level readback
    always_ff @(posedge clk or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            pin_level <= '0;
        end else begin
            pin_level <= pin_sync;
        end
    end

    // Terminal or remote value
    assign terminal_sync = pin_sync[csss_pkg::PIN_TERMINAL_LSB +: csss_pkg::TERMINAL_COUNT];

    always_comb begin
        for (int i = 0; i < csss_pkg::TERMINAL_COUNT; i++) begin
            terminal_src[i] = remote_enable[i] ? remote_value[i] : terminal_sync[i];
        end
    end

    // Multifunction input only in digital mode
    always_comb begin
        if (multifunction_mode == csss_pkg::MF_MODE_DIGITAL
                && !remote_enable[csss_pkg::REMOTE_MF_BIT]) begin
            multifunction_src = pin_sync[csss_pkg::PIN_MULTIFUNC];
        end else begin
            multifunction_src = remote_value[csss_pkg::REMOTE_MF_BIT];
        end
    end

    // Both torque-off paths enabled
    assign both_enables = pin_sync[csss_pkg::PIN_ENABLE_A] & pin_sync[csss_pkg::PIN_ENABLE_B];

    // Technology controller configurations
    assign tech_config = (device_config == csss_pkg::CONFIG_TECH_A)
                       || (device_config == csss_pkg::CONFIG_TECH_B)
                       || (device_config == csss_pkg::CONFIG_TECH_C);

    // Temperature limits as temp plus margin against maximum
    assign heat_sink_sum = {1'b0, heat_sink_temp} + {1'b0, heat_sink_margin};
    assign inside_sum    = {1'b0, inside_temp} + {1'b0, inside_margin};
    assign heat_sink_hit = heat_sink_sum >= {1'b0, csss_pkg::HEAT_SINK_MAX_C};
    assign inside_hit    = inside_sum >= {1'b0, csss_pkg::INSIDE_MAX_C};

    // Source flags
    always_comb begin
        srcs.src               = '0;
        srcs.src.tech_start    = tech_start_cmd & tech_config;
        srcs.src.input_group   = {multifunction_src, terminal_src, both_enables};
        srcs.src.warning_mask  = |(warning_active & warning_critical & warning_mask);
        srcs.src.timer_1       = timer_1_out;
        srcs.src.timer_2       = timer_2_out;
        srcs.src.ready         = init_done;
        srcs.src.run           = both_enables & start_cmd & freq_output_active;
        srcs.src.error         = fault_reported;
        srcs.src.freq_reached  = actual_freq >= reference_freq;
        srcs.src.setting_freq  = stator_freq > setting_freq;
        srcs.src.overload      = overload_reported;
        srcs.src.heat_sink     = heat_sink_hit;
        srcs.src.inside_temp   = inside_hit;
        srcs.src.motor_temp    = thermistor_max
                               && (motor_temp_mode != csss_pkg::MOTOR_MODE_OFF);
        srcs.src.general_warn  = |(warning_active & warning_critical);
        srcs.src.over_temp     = heat_sink_hit | inside_hit;
        srcs.src.comp_1        = comp_1_out;
        srcs.src.comp_2        = comp_2_out;
        srcs.src.digital_1     = digital_signal_1;
        srcs.src.digital_2     = digital_signal_2;
        srcs.src.digital_3     = digital_signal_3;
        srcs.src.percent_reach = actual_percent >= reference_percent;
    end

    // Function input selectors
    genvar g;
    generate
        for (g = 0; g < csss_pkg::FUNC_COUNT; g++) begin : gen_func
            localparam logic [csss_pkg::FUNC_INDEX_W-1:0] SLOT = csss_pkg::FUNC_INDEX_W'(g);
            csss_selector u_sel (
                .clk       (clk),
                .rst_n     (sys_rst_n),
                .load      (cfg_write && (cfg_index == SLOT)),
                .load_code (cfg_code),
                .srcs      (srcs.take),
                .level     (level[g])
            );
        end
    endgenerate

    assign func_level = level;

endmodule

//--- tb/csss_monitor.sv
// Assertion checker on the source selector top ports
`timescale 1ns/1ns
module csss_monitor (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       cfg_write,
    input wire logic [2:0] cfg_index,
    input wire logic [8:0] cfg_code,
    input wire logic       torque_off_enable_a,
    input wire logic       torque_off_enable_b,
    input wire logic       terminal_input_2,
    input wire logic       terminal_input_3,
    input wire logic       terminal_input_4,
    input wire logic       terminal_input_5,
    input wire logic       terminal_input_6,
    input wire logic       multifunction_input,
    input wire logic       init_done,
    input wire logic       start_cmd,
    input wire logic       freq_output_active,
    input wire logic       comp_1_out,
    input wire logic [7:0] heat_sink_temp,
    input wire logic [7:0] heat_sink_margin,
    input wire logic [7:0] func_level,
    input wire logic [7:0] pin_level
);
    logic [8:0] code0;
    logic [2:0] up;
    // Shadow of slot 0 code and cycles since reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) code0 <= csss_pkg::CODE_RESET;
        else if (cfg_write && cfg_index == 3'h0) code0 <= cfg_code;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) up <= 3'h0;
        else if (up != 3'h7) up <= up + 3'h1;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_held(logic [8:0] c);
        code0 == c && $past(code0) == c;
    endsequence
    sequence s_wr0(logic [8:0] c);
        cfg_write && cfg_index == 3'h0 && cfg_code == c;
    endsequence
    property p_on;
        s_wr0(csss_pkg::CODE_ON) |-> ##2 func_level[0];
    endproperty
    a_on: assert property (p_on) else $error("constant on not seen");
    property p_off;
        s_wr0(csss_pkg::CODE_OFF) |-> ##2 !func_level[0];
    endproperty
    a_off: assert property (p_off) else $error("constant off not seen");
    property p_release;
        s_held(csss_pkg::CODE_DRIVE_RELEASE) |-> func_level[0] == (pin_level[0] & pin_level[1]);
    endproperty
    a_release: assert property (p_release) else $error("drive release wrong");
    property p_inv;
        s_held(csss_pkg::CODE_INV_FIRST) |-> func_level[0] == !(pin_level[0] & pin_level[1]);
    endproperty
    a_inv: assert property (p_inv) else $error("inverted release wrong");
    property p_ready;
        s_held(csss_pkg::CODE_READY) |-> func_level[0] == $past(init_done);
    endproperty
    a_ready: assert property (p_ready) else $error("ready level wrong");
    property p_run;
        s_held(csss_pkg::CODE_RUN) |-> func_level[0] ==
            ($past(start_cmd) && $past(freq_output_active) && pin_level[0] && pin_level[1]);
    endproperty
    a_run: assert property (p_run) else $error("run level wrong");
    property p_heat;
        s_held(csss_pkg::CODE_HEAT_SINK) |-> func_level[0] ==
            ({1'b0, $past(heat_sink_temp)} + {1'b0, $past(heat_sink_margin)} >= 9'h050);
    endproperty
    a_heat: assert property (p_heat) else $error("heat sink warning wrong");
    property p_comp_n;
        s_held(csss_pkg::CODE_COMP_1_N) |-> func_level[0] == !$past(comp_1_out);
    endproperty
    a_comp_n: assert property (p_comp_n) else $error("negated comparator wrong");
    property p_bad;
        s_held(9'h1FF) |-> !func_level[0];
    endproperty
    a_bad: assert property (p_bad) else $error("unsupported code not low");
    wire [7:0] pins = {multifunction_input, terminal_input_6, terminal_input_5,
        terminal_input_4, terminal_input_3, terminal_input_2, torque_off_enable_b,
        torque_off_enable_a};
    property p_pins;
        up == 3'h7 |-> pin_level == $past(pins, 3);
    endproperty
    a_pins: assert property (p_pins) else $error("pin sync delay wrong");
endmodule
bind csss_top csss_monitor u_csss_monitor (.*);

//--- tb/csss_far_pins.sv
// Terminal side model driving the pins after each rising clock edge
`timescale 1ns/1ns
module csss_far_pins (
    input wire logic [7:0] want,
    input wire logic       clk,
    output     logic       torque_off_enable_a, torque_off_enable_b, terminal_input_2,
    output     logic       terminal_input_3, terminal_input_4, terminal_input_5,
    output     logic       terminal_input_6, multifunction_input
);
    initial {multifunction_input, terminal_input_6, terminal_input_5, terminal_input_4,
        terminal_input_3, terminal_input_2, torque_off_enable_b, torque_off_enable_a} = 8'h00;
    always @(posedge clk) begin
        {multifunction_input, terminal_input_6, terminal_input_5, terminal_input_4,
            terminal_input_3, terminal_input_2, torque_off_enable_b,
            torque_off_enable_a} <= #1 want;
    end
endmodule

//--- tb/tb_control_signal_source_select.sv
// Self-checking bench for the source selector
`timescale 1ns/1ns
module tb_control_signal_source_select;
    logic clk = 0, rst_n = 0, cfg_write = 0, tech_start_cmd = 0, timer_1_out = 0;
    logic timer_2_out = 0, init_done = 0, start_cmd = 0, freq_output_active = 0;
    logic fault_reported = 0, overload_reported = 0, thermistor_max = 0, comp_1_out = 0;
    logic comp_2_out = 0, digital_signal_1 = 0, digital_signal_2 = 0, digital_signal_3 = 0;
    logic [2:0] cfg_index = 3'h0;
    logic [8:0] cfg_code = 9'h000, device_config = 9'h000;
    logic [7:0] want = 8'h00, heat_sink_margin = 8'h00, inside_margin = 8'h00;
    logic [7:0] heat_sink_temp = 8'h00, inside_temp = 8'h00, func_level, pin_level;
    logic [5:0] remote_enable = 6'h00, remote_value = 6'h00;
    logic [3:0] multifunction_mode = 4'h0, motor_temp_mode = 4'h0;
    logic [15:0] warning_mask = 16'h0000, warning_active = 16'h0000;
    logic [15:0] warning_critical = 16'h0000, setting_freq = 16'h0000;
    logic [15:0] actual_freq = 16'h0000, reference_freq = 16'h0000, stator_freq = 16'h0000;
    logic [15:0] actual_percent = 16'h0000, reference_percent = 16'h0000;
    wire torque_off_enable_a, torque_off_enable_b, terminal_input_2, terminal_input_3;
    wire terminal_input_4, terminal_input_5, terminal_input_6, multifunction_input;
    int err_total = 0, num_checks = 0, cyc = 0;
    csss_far_pins u_csss_far_pins (.*);
    csss_top u_csss_top (.*);
    always #10 clk = ~clk;
    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t level %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] idx, input logic [8:0] c);
        @(posedge clk); #1 cfg_write = 1; cfg_index = idx; cfg_code = c;
        @(posedge clk); #1 cfg_write = 0;
    endtask
    task automatic lv(input logic [2:0] idx, input logic exp);
        repeat (4) @(posedge clk);
        #1 chk({7'h00, func_level[idx]}, {7'h00, exp});
    endtask
    task automatic t_const;
        wr(0, csss_pkg::CODE_ON); lv(0, 1);
        wr(7, csss_pkg::CODE_ON); lv(7, 1);
        wr(0, csss_pkg::CODE_OFF); lv(0, 0);
        wr(0, 9'h1FF); lv(0, 0);
    endtask
    task automatic t_release;
        want = 8'h03; wr(0, csss_pkg::CODE_DRIVE_RELEASE); lv(0, 1);
        chk(pin_level, 8'h03);
        want = 8'h01; lv(0, 0);
        wr(0, csss_pkg::CODE_INV_FIRST); lv(0, 1);
        want = 8'h03; start_cmd = 1; freq_output_active = 1;
        wr(0, csss_pkg::CODE_RUN); lv(0, 1);
        freq_output_active = 0; lv(0, 0);
    endtask
    task automatic t_remote;
        want = 8'h00; remote_enable = 6'h01; remote_value = 6'h01;
        wr(0, csss_pkg::CODE_DRIVE_RELEASE + 9'h001); lv(0, 1);
        remote_enable = 6'h00; want = 8'h04; lv(0, 1);
        wr(0, csss_pkg::CODE_MULTIFUNCTION); want = 8'h80;
        multifunction_mode = csss_pkg::MF_MODE_DIGITAL; lv(0, 1);
        multifunction_mode = 4'h0; remote_value = 6'h00; lv(0, 0);
        remote_value = 6'h20; lv(0, 1);
    endtask
    task automatic t_status;
        heat_sink_margin = 8'h0A; heat_sink_temp = 8'h46;
        wr(0, csss_pkg::CODE_HEAT_SINK); lv(0, 1);
        heat_sink_temp = 8'h45; lv(0, 0);
        comp_1_out = 1; wr(0, csss_pkg::CODE_COMP_1_N); lv(0, 0);
        comp_1_out = 0; lv(0, 1);
        init_done = 1; wr(0, csss_pkg::CODE_READY); lv(0, 1);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        #1 rst_n = 1;
        repeat (3) @(posedge clk);
        t_const();
        t_release();
        t_remote();
        t_status();
        print_verdict();
    end
endmodule
